//--- rtl/admcc_consts.svh
// Constants for the ADC mode and clock control block
`ifndef ADMCC_CONSTS_SVH
`define ADMCC_CONSTS_SVH
// System and internal oscillator rates, kHz
`define ADMCC_SYS_KHZ     125000
`define ADMCC_INT_KHZ     64
// Half period of the internal clock in system cycles
`define ADMCC_HALF_CNT    (`ADMCC_SYS_KHZ / (2 * `ADMCC_INT_KHZ))
// Clock source codes
`define ADMCC_SRC_INT     2'h0
`define ADMCC_SRC_INT_OUT 2'h1
`define ADMCC_SRC_EXT     2'h2
`define ADMCC_SRC_EXT_DIV 2'h3
// Mode register fields
`define ADMCC_MD_HI       15
`define ADMCC_MD_LO       13
`define ADMCC_AMPCM_BIT   9
`define ADMCC_SRC_HI      7
`define ADMCC_SRC_LO      6
`define ADMCC_CHOPDIS_BIT 4
`define ADMCC_FS_HI       3
`define ADMCC_FS_LO       0
`define ADMCC_MODE_RST    16'h0000
// Operating mode codes
`define ADMCC_MD_CONT     3'h0
`define ADMCC_MD_SINGLE   3'h1
`define ADMCC_MD_PDOWN    3'h3
// Command byte fields and register addresses
`define ADMCC_CMD_WEN     7
`define ADMCC_CMD_RD      6
`define ADMCC_CMD_AHI     5
`define ADMCC_CMD_ALO     3
`define ADMCC_CMD_CREAD   2
`define ADMCC_ADDR_STAT   3'h0
`define ADMCC_ADDR_MODE   3'h1
`define ADMCC_ADDR_DATA   3'h3
// Transfer lengths in bits
`define ADMCC_LEN_BYTE    5'h08
`define ADMCC_LEN_MODE    5'h10
`define ADMCC_LEN_DATA    5'h18
// Conversion period is (rate select + 1) * 16 conversion clock ticks
`define ADMCC_RATE_PAD    4'h0
`endif

//--- rtl/admcc_pkg.sv
// Types for the ADC mode and clock control block
package admcc_pkg;
  typedef enum logic [1:0] {
    SER_CMD = 2'b00,
    SER_WR  = 2'b01,
    SER_RD  = 2'b11,
    SER_CRD = 2'b10
  } admcc_ser_t;
endpackage : admcc_pkg

//--- rtl/admcc_clk_src.sv
// Conversion clock source select and tick generator
`include "admcc_consts.svh"
module admcc_clk_src
  import admcc_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic [1:0] clk_src,
  input  wire logic       ext_clk_i,
  output logic            adc_tick,
  output logic            int_clk_lvl
);
  logic [9:0] half_cnt_ff;
  logic [9:0] nxt_half_cnt;
  logic       int_lvl_ff;
  logic       nxt_int_lvl;
  logic       ext_prev_ff;
  logic       div_ff;
  logic       nxt_div;
  logic       wrap;
  logic       ext_rise;

  // Divider for the internal oscillator and external edge handling
  always_comb begin
    wrap = (half_cnt_ff == 10'(`ADMCC_HALF_CNT - 1));
    nxt_half_cnt = wrap ? 10'h000 : half_cnt_ff + 10'h001;
    nxt_int_lvl = wrap ? !int_lvl_ff : int_lvl_ff;
    ext_rise = ext_clk_i & !ext_prev_ff;
    nxt_div = div_ff;
    if (clk_src == `ADMCC_SRC_EXT_DIV && ext_rise) begin
      nxt_div = !div_ff; // RULE3
    end
    case (clk_src)
      `ADMCC_SRC_INT,
      `ADMCC_SRC_INT_OUT: adc_tick = wrap & !int_lvl_ff;
      `ADMCC_SRC_EXT:     adc_tick = ext_rise;
      `ADMCC_SRC_EXT_DIV: adc_tick = ext_rise & div_ff; // RULE3
      default:            adc_tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      half_cnt_ff <= 10'h000;
      int_lvl_ff  <= 1'b0;
      ext_prev_ff <= 1'b0;
      div_ff      <= 1'b0;
    end else begin
      half_cnt_ff <= nxt_half_cnt;
      int_lvl_ff  <= nxt_int_lvl;
      ext_prev_ff <= ext_clk_i;
      div_ff      <= nxt_div;
    end
  end

  assign int_clk_lvl = int_lvl_ff;

  // Every other external rising edge is swallowed in divide mode
  AST_DIV_HALF: assert property ( // RULE3
    @(posedge clk_sys) disable iff (!rst_b)
    (clk_src == `ADMCC_SRC_EXT_DIV && ext_rise && !div_ff) |->
      !adc_tick ##1 (div_ff == 1'b1))
    else $error("divide by two tick on wrong edge");
endmodule : admcc_clk_src

//--- rtl/admcc_buf2.sv
// Two-entry result buffer with valid and ready on both sides
module admcc_buf2
  import admcc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire logic [23:0] in_data,
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic [23:0]      out_data
);
  logic [23:0] mem_ff [2];
  logic [23:0] nxt_mem [2];
  logic        wr_ptr_ff;
  logic        nxt_wr_ptr;
  logic        rd_ptr_ff;
  logic        nxt_rd_ptr;
  logic [1:0]  cnt_ff;
  logic [1:0]  nxt_cnt;
  logic        push;
  logic        pop;

  // Pointer and count update
  always_comb begin
    in_ready = (cnt_ff != 2'h2);
    out_valid = (cnt_ff != 2'h0);
    out_data = mem_ff[rd_ptr_ff];
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    nxt_mem = mem_ff;
    if (push) begin
      nxt_mem[wr_ptr_ff] = in_data;
    end
    nxt_wr_ptr = wr_ptr_ff ^ push;
    nxt_rd_ptr = rd_ptr_ff ^ pop;
    nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mem_ff[0] <= 24'h00_0000;
      mem_ff[1] <= 24'h00_0000;
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      cnt_ff    <= 2'h0;
    end else begin
      mem_ff    <= nxt_mem;
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      cnt_ff    <= nxt_cnt;
    end
  end
endmodule : admcc_buf2

//--- rtl/admcc_top.sv
// ADC mode register, clock source, conversion timing and serial port
`include "admcc_consts.svh"
// How it works
// [RULE1] Source 01: internal 64 kHz clock, also driven out on clock pin.
// [RULE2] Source 10: outside party supplies 64 kHz, duty within 45:55.
// [RULE3] Source 11: external clock is halved to make conversion clock.
// [RULE4] Software writes zero to mode bit 5.
// [RULE5] Chop-disable bit 4 clear after reset; setting it stops chopping.
// [RULE6] Software should set amp common-mode bit when chop is off.
// [RULE7] Mode bits 3..0 pick the update rate, setting conversion period.
// [RULE8] Mode field zero is continuous conversion, the reset mode.
// [RULE9] Continuous mode converts back to back, loading each result; here a full buffer with a result pending stalls the next conversion.
// [RULE10] Ready flag goes low when a finished result is available.
// [RULE11] Continuous read shifts each result out without any command.
// [RULE12] Otherwise a read command makes the data register shift out.
// [RULE13] First result after two periods with chop, one without.
// [RULE14] Later results follow every period, chop on or off.
// [RULE15] Operating mode field sits in mode bits 15..13.
// [RULE16] Source 00: internal 64 kHz clock, clock pin not driven.
// [RULE17] Single mode: one conversion, ready low, then power-down.
// [RULE18] Ready flag rises once the result has been fully read.
module admcc_top
  import admcc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        sclk,
  input  wire logic        cs_b,
  input  wire logic        din,
  output logic             dout,
  output logic             rdy_b,
  input  wire logic        clk_pin_i,
  output logic             clk_pin_o,
  output logic             clk_pin_oe,
  input  wire logic [23:0] filter_data,
  output logic             chop_active,
  output logic             amp_common_mode_narrow,
  output logic [3:0]       update_rate_select,
  output logic             modulator_run
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  logic [15:0] mode_ff;
  logic [15:0] nxt_mode;
  admcc_ser_t  ser_st_ff;
  admcc_ser_t  nxt_ser_st;
  logic [4:0]  bit_cnt_ff;
  logic [4:0]  nxt_bit_cnt;
  logic [4:0]  len_ff;
  logic [4:0]  nxt_len;
  logic [2:0]  rd_addr_ff;
  logic [2:0]  nxt_rd_addr;
  logic        cread_ff;
  logic        nxt_cread;
  logic        held_ff;
  logic        nxt_held;
  logic [15:0] shin_ff;
  logic [15:0] nxt_shin;
  logic [23:0] shout_ff;
  logic [23:0] nxt_shout;
  logic        sclk_prev_ff;
  logic        dout_ff;
  logic        nxt_dout;
  logic [8:0]  tick_cnt_ff;
  logic [8:0]  nxt_tick_cnt;
  logic [1:0]  per_cnt_ff;
  logic [1:0]  nxt_per_cnt;
  logic        first_ff;
  logic        nxt_first;
  logic        pend_ff;
  logic        nxt_pend;
  logic [23:0] result_ff;
  logic [23:0] nxt_result;
  logic        rdy_b_ff;
  logic        clk_o_ff;
  logic        clk_oe_ff;
  logic        chop_ff;
  logic        ampcm_ff;
  logic [3:0]  fs_ff;
  logic        run_ff;
  logic        adc_tick;
  logic        int_lvl;
  logic        in_ready;
  logic        out_valid;
  logic [23:0] out_data;
  logic        pop;
  logic        wr_mode;
  logic        go_pdown;
  logic        conv_done;
  logic        sclk_rise;
  logic        sclk_fall;
  logic [7:0]  cmd;
  logic [15:0] wr_val;
  logic [23:0] rd_word;
  logic [2:0]  md;
  logic [1:0]  clk_src;
  logic        chop_on;
  logic        converting;
  logic [4:0]  fs_p1;
  logic [8:0]  period_m1;

  // Mode register fields
  assign md = mode_ff[`ADMCC_MD_HI:`ADMCC_MD_LO]; // RULE15
  assign clk_src = mode_ff[`ADMCC_SRC_HI:`ADMCC_SRC_LO];
  assign chop_on = !mode_ff[`ADMCC_CHOPDIS_BIT]; // RULE5
  assign converting = (md == `ADMCC_MD_CONT) || (md == `ADMCC_MD_SINGLE);

  admcc_clk_src u_clk_src (
    .clk_sys     (clk_sys),
    .rst_b       (rst_b),
    .clk_src     (clk_src),
    .ext_clk_i   (clk_pin_i),
    .adc_tick    (adc_tick),
    .int_clk_lvl (int_lvl)
  );

  // Results wait here while the host is slow to read them
  admcc_buf2 u_buf (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .in_valid  (pend_ff),
    .in_ready  (in_ready),
    .in_data   (result_ff),
    .out_valid (out_valid),
    .out_ready (pop),
    .out_data  (out_data)
  );

  // Register read word, left aligned in the shifter
  function automatic logic [23:0] reg_word(input logic [2:0]  a,
                                           input logic [15:0] m,
                                           input logic        r,
                                           input logic [23:0] d);
    case (a)
      `ADMCC_ADDR_STAT: reg_word = {r, 23'h00_0000};
      `ADMCC_ADDR_MODE: reg_word = {m, 8'h00};
      `ADMCC_ADDR_DATA: reg_word = d;
      default:          reg_word = 24'h00_0000;
    endcase
  endfunction : reg_word

  function automatic logic [4:0] reg_len(input logic [2:0] a);
    case (a)
      `ADMCC_ADDR_MODE: reg_len = `ADMCC_LEN_MODE;
      `ADMCC_ADDR_DATA: reg_len = `ADMCC_LEN_DATA;
      default:          reg_len = `ADMCC_LEN_BYTE;
    endcase
  endfunction : reg_len

  // Serial port: sample on rising sclk, change dout on falling sclk
  always_comb begin
    sclk_rise = sclk & !sclk_prev_ff;
    sclk_fall = !sclk & sclk_prev_ff;
    cmd = {shin_ff[6:0], din};
    wr_val = {shin_ff[14:0], din};
    rd_word = reg_word(rd_addr_ff, mode_ff, rdy_b_ff, out_data);
    nxt_ser_st = ser_st_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_len = len_ff;
    nxt_rd_addr = rd_addr_ff;
    nxt_cread = cread_ff;
    nxt_held = held_ff;
    nxt_shin = shin_ff;
    nxt_shout = shout_ff;
    nxt_dout = dout_ff;
    wr_mode = 1'b0;
    pop = 1'b0;
    if (cs_b) begin
      // Deselect aborts any transfer and leaves continuous read
      nxt_ser_st = SER_CMD;
      nxt_bit_cnt = 5'h00;
      nxt_cread = 1'b0;
    end else begin
      case (ser_st_ff)
        SER_CMD: begin
          if (sclk_rise) begin
            nxt_shin = {shin_ff[14:0], din};
            nxt_bit_cnt = bit_cnt_ff + 5'h01;
            if (bit_cnt_ff == `ADMCC_LEN_BYTE - 5'h01) begin
              nxt_bit_cnt = 5'h00;
              // A set enable bit means the byte is not a command
              if (!cmd[`ADMCC_CMD_WEN]) begin
                nxt_rd_addr = cmd[`ADMCC_CMD_AHI:`ADMCC_CMD_ALO];
                nxt_len = reg_len(cmd[`ADMCC_CMD_AHI:`ADMCC_CMD_ALO]);
                if (!cmd[`ADMCC_CMD_RD]) begin
                  nxt_ser_st = SER_WR;
                end else if (cmd[`ADMCC_CMD_CREAD] &&
                             cmd[`ADMCC_CMD_AHI:`ADMCC_CMD_ALO] ==
                             `ADMCC_ADDR_DATA) begin
                  nxt_ser_st = SER_CRD; // RULE11
                  nxt_cread = 1'b1;
                end else begin
                  nxt_ser_st = SER_RD; // RULE12
                end
              end
            end
          end
        end
        SER_WR: begin
          if (sclk_rise) begin
            nxt_shin = wr_val;
            nxt_bit_cnt = bit_cnt_ff + 5'h01;
            if (bit_cnt_ff == len_ff - 5'h01) begin
              nxt_bit_cnt = 5'h00;
              nxt_ser_st = SER_CMD;
              wr_mode = (rd_addr_ff == `ADMCC_ADDR_MODE);
            end
          end
        end
        SER_RD: begin
          if (sclk_fall) begin
            if (bit_cnt_ff == 5'h00) begin
              nxt_shout = rd_word; // RULE12
              nxt_dout = rd_word[23];
              nxt_held = out_valid && (rd_addr_ff == `ADMCC_ADDR_DATA);
            end else begin
              nxt_shout = {shout_ff[22:0], 1'b0};
              nxt_dout = shout_ff[22];
            end
          end
          if (sclk_rise) begin
            nxt_bit_cnt = bit_cnt_ff + 5'h01;
            if (bit_cnt_ff == len_ff - 5'h01) begin
              nxt_bit_cnt = 5'h00;
              pop = held_ff; // RULE18
              nxt_held = 1'b0;
              nxt_ser_st = cread_ff ? SER_CRD : SER_CMD;
            end
          end
        end
        SER_CRD: begin
          // Falling edges before a result is ready are ignored
          if (sclk_fall && out_valid) begin
            nxt_shout = out_data; // RULE11
            nxt_dout = out_data[23];
            nxt_held = 1'b1;
            nxt_len = `ADMCC_LEN_DATA;
            nxt_rd_addr = `ADMCC_ADDR_DATA;
            nxt_bit_cnt = 5'h00;
            nxt_ser_st = SER_RD;
          end
        end
        default: nxt_ser_st = SER_CMD;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ser_st_ff    <= SER_CMD;
      bit_cnt_ff   <= 5'h00;
      len_ff       <= `ADMCC_LEN_BYTE;
      rd_addr_ff   <= `ADMCC_ADDR_STAT;
      cread_ff     <= 1'b0;
      held_ff      <= 1'b0;
      shin_ff      <= 16'h0000;
      shout_ff     <= 24'h00_0000;
      sclk_prev_ff <= 1'b1;
      dout_ff      <= 1'b0;
    end else begin
      ser_st_ff    <= nxt_ser_st;
      bit_cnt_ff   <= nxt_bit_cnt;
      len_ff       <= nxt_len;
      rd_addr_ff   <= nxt_rd_addr;
      cread_ff     <= nxt_cread;
      held_ff      <= nxt_held;
      shin_ff      <= nxt_shin;
      shout_ff     <= nxt_shout;
      sclk_prev_ff <= sclk;
      dout_ff      <= nxt_dout;
    end
  end

  // Mode register: host writes win over the single-shot power-down
  always_comb begin
    nxt_mode = mode_ff;
    if (wr_mode) begin
      nxt_mode = wr_val;
    end else if (go_pdown) begin
      nxt_mode[`ADMCC_MD_HI:`ADMCC_MD_LO] = `ADMCC_MD_PDOWN; // RULE17
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_ff <= `ADMCC_MODE_RST; // RULE8 RULE5
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // Conversion timing; a full buffer stalls the next conversion
  always_comb begin
    fs_p1 = {1'b0, mode_ff[`ADMCC_FS_HI:`ADMCC_FS_LO]} + 5'h01;
    period_m1 = {fs_p1, `ADMCC_RATE_PAD} - 9'h001; // RULE7
    nxt_tick_cnt = tick_cnt_ff;
    nxt_per_cnt = per_cnt_ff;
    nxt_first = first_ff;
    nxt_pend = pend_ff;
    nxt_result = result_ff;
    conv_done = 1'b0;
    go_pdown = 1'b0;
    if (wr_mode) begin
      // A new setting restarts the filter settling
      nxt_tick_cnt = 9'h000;
      nxt_per_cnt = 2'h0;
      nxt_first = 1'b1;
      nxt_pend = 1'b0;
    end else begin
      if (pend_ff && in_ready) begin
        nxt_pend = 1'b0;
        go_pdown = (md == `ADMCC_MD_SINGLE); // RULE17
      end
      if (adc_tick && converting && !pend_ff) begin
        if (tick_cnt_ff == period_m1) begin
          nxt_tick_cnt = 9'h000;
          if (first_ff && chop_on && per_cnt_ff == 2'h0) begin
            nxt_per_cnt = 2'h1; // RULE13
          end else begin
            nxt_per_cnt = 2'h0; // RULE14
            nxt_first = 1'b0;
            nxt_pend = 1'b1; // RULE9
            nxt_result = filter_data;
            conv_done = 1'b1;
          end
        end else begin
          nxt_tick_cnt = tick_cnt_ff + 9'h001;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_ff <= 9'h000;
      per_cnt_ff  <= 2'h0;
      first_ff    <= 1'b1;
      pend_ff     <= 1'b0;
      result_ff   <= 24'h00_0000;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
      per_cnt_ff  <= nxt_per_cnt;
      first_ff    <= nxt_first;
      pend_ff     <= nxt_pend;
      result_ff   <= nxt_result;
    end
  end

  // Registered outputs
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdy_b_ff  <= 1'b1;
      clk_o_ff  <= 1'b0;
      clk_oe_ff <= 1'b0;
      chop_ff   <= 1'b1;
      ampcm_ff  <= 1'b0;
      fs_ff     <= 4'h0;
      run_ff    <= 1'b0;
    end else begin
      rdy_b_ff  <= !out_valid; // RULE10 RULE18
      clk_oe_ff <= (clk_src == `ADMCC_SRC_INT_OUT); // RULE1 RULE16
      clk_o_ff  <= int_lvl & (clk_src == `ADMCC_SRC_INT_OUT); // RULE1
      chop_ff   <= chop_on; // RULE5
      ampcm_ff  <= mode_ff[`ADMCC_AMPCM_BIT];
      fs_ff     <= mode_ff[`ADMCC_FS_HI:`ADMCC_FS_LO]; // RULE7
      run_ff    <= converting;
    end
  end

  assign dout = dout_ff;
  assign rdy_b = rdy_b_ff;
  assign clk_pin_o = clk_o_ff;
  assign clk_pin_oe = clk_oe_ff;
  assign chop_active = chop_ff;
  assign amp_common_mode_narrow = ampcm_ff;
  assign update_rate_select = fs_ff;
  assign modulator_run = run_ff;

  AST_CLK_DRIVE: assert property ( // RULE1
    (clk_src == `ADMCC_SRC_INT_OUT) |=>
      clk_pin_oe && (clk_pin_o == $past(int_lvl)))
    else $error("internal clock not driven on clock pin");
  AST_CLK_QUIET: assert property ( // RULE16
    (clk_src == `ADMCC_SRC_INT) |=> !clk_pin_oe)
    else $error("clock pin driven with source 00");
  AST_CHOP: assert property ( // RULE5
    $changed(mode_ff[`ADMCC_CHOPDIS_BIT]) |=>
      (chop_active == !$past(mode_ff[`ADMCC_CHOPDIS_BIT])))
    else $error("chop output does not follow disable bit");
  AST_RDY_LOW: assert property ( // RULE10
    $rose(out_valid) |=> !rdy_b)
    else $error("ready flag not low after result");
  AST_RDY_POP: assert property ( // RULE18
    pop |-> (ser_st_ff == SER_RD) && out_valid && sclk_rise)
    else $error("result released without full read");
  AST_FIRST: assert property ( // RULE13
    (conv_done && first_ff) |-> (per_cnt_ff == (chop_on ? 2'h1 : 2'h0)))
    else $error("first result after wrong number of periods");
  AST_NEXT: assert property ( // RULE14
    (conv_done && !first_ff) |-> (per_cnt_ff == 2'h0))
    else $error("later result not after one period");
  AST_CONT: assert property ( // RULE9
    (md == `ADMCC_MD_CONT && conv_done) |=>
      pend_ff ##0 (md == `ADMCC_MD_CONT || $past(wr_mode)))
    else $error("continuous result not loaded");
  AST_SINGLE: assert property ( // RULE17
    (md == `ADMCC_MD_SINGLE && pend_ff && in_ready && !wr_mode) |=>
      (mode_ff[`ADMCC_MD_HI:`ADMCC_MD_LO] == `ADMCC_MD_PDOWN))
    else $error("single conversion did not power down");
  AST_CREAD: assert property ( // RULE11
    (ser_st_ff == SER_CRD && sclk_fall && out_valid && !cs_b) |=>
      (ser_st_ff == SER_RD) && (dout == $past(out_data[23])))
    else $error("continuous read did not present result");
endmodule : admcc_top

//--- bench/admcc_host.sv
// Host serial master and external conversion clock for the mode block
module admcc_host (
  input  wire logic clk_sys,
  input  wire logic dout,
  output logic      sclk,
  output logic      cs_b,
  output logic      din,
  output logic      clk_pin_i
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [1:0] div_ff;

  // Idle bus: clock high, not selected
  initial begin
    sclk = 1'h1;
    cs_b = 1'h1;
    din = 1'h0;
    clk_pin_i = 1'h0;
    div_ff = 2'h0;
  end

  // Even duty external clock, eight system cycles a period
  always @(posedge clk_sys) begin
    div_ff <= #1 div_ff + 2'h1;
    if (div_ff == 2'h3) clk_pin_i <= #1 ~clk_pin_i;
  end

  // Wait n edges, then move just past the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step

  // Select or release; a released data line flips so no stale bit is seen
  task automatic sel(input logic v);
    cs_b = v;
    if (v) din = ~din;
    step(2);
  endtask : sel

  // Shift n bits MSB first, dout sampled late in each low phase
  task automatic bits(input int n, input logic [23:0] w,
                      output logic [23:0] r);
    r = 24'h00_0000;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'h0;
      din = w[i];
      step(3);
      r = {r[22:0], dout};
      sclk = 1'h1;
      step(3);
    end
  endtask : bits
endmodule : admcc_host

//--- bench/tb_top.sv
// Self-checking bench for the ADC mode and clock control block
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_sys;
  logic        rst_b;
  logic        sclk;
  logic        cs_b;
  logic        din;
  logic        dout;
  logic        rdy_b;
  logic        clk_pin_i;
  logic        clk_pin_o;
  logic        clk_pin_oe;
  logic        chop_active;
  logic        amp_common_mode_narrow;
  logic        modulator_run;
  logic        v;
  logic [3:0]  update_rate_select;
  logic [23:0] filter_data;
  logic [23:0] r;
  int          num_errors;
  int          cmp_count;
  int          cyc;
  int          t0;

  admcc_top i_admcc_top (
    .clk_sys                (clk_sys),
    .rst_b                  (rst_b),
    .sclk                   (sclk),
    .cs_b                   (cs_b),
    .din                    (din),
    .dout                   (dout),
    .rdy_b                  (rdy_b),
    .clk_pin_i              (clk_pin_i),
    .clk_pin_o              (clk_pin_o),
    .clk_pin_oe             (clk_pin_oe),
    .filter_data            (filter_data),
    .chop_active            (chop_active),
    .amp_common_mode_narrow (amp_common_mode_narrow),
    .update_rate_select     (update_rate_select),
    .modulator_run          (modulator_run)
  );

  admcc_host i_admcc_host (
    .clk_sys   (clk_sys),
    .dout      (dout),
    .sclk      (sclk),
    .cs_b      (cs_b),
    .din       (din),
    .clk_pin_i (clk_pin_i)
  );

  // 125 MHz system clock
  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Free cycle count for timing checks
  always @(posedge clk_sys) cyc <= cyc + 1;

  task automatic finish_test();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [23:0] e,
                     input logic [23:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // Allows a few conversion ticks of phase slack at the edges
  task automatic chk_win(input string nm, input int e, input int g);
    cmp_count++;
    if (g < e - 24 || g > e + 24) begin
      num_errors++;
      $display("CHECK FAILED %s exp %0d got %0d", nm, e, g);
    end
  endtask : chk_win

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    i_admcc_host.sel(1'h0);
    i_admcc_host.bits(8, {16'h0000, c}, r);
    i_admcc_host.bits(16, {8'h00, d}, r);
    i_admcc_host.sel(1'h1);
  endtask : wr

  task automatic rd(input logic [7:0] c, input int n,
                    output logic [23:0] q);
    i_admcc_host.sel(1'h0);
    i_admcc_host.bits(8, {16'h0000, c}, q);
    i_admcc_host.bits(n, 24'h00_0000, q);
    i_admcc_host.sel(1'h1);
  endtask : rd

  // Bounded wait for a result; running out ends the run
  task automatic wait_rdy();
    for (int i = 0; i < 3000 && rdy_b !== 1'h0; i++) i_admcc_host.step(1);
    if (rdy_b !== 1'h0) begin
      num_errors++;
      $display("CHECK FAILED rdy_b wait exp 0 got %b", rdy_b);
      finish_test();
    end
  endtask : wait_rdy

  initial begin
    rst_b = 1'h0;
    cyc = 0;
    num_errors = 0;
    cmp_count = 0;
    filter_data = 24'hA5_0001;
    repeat (16) @(posedge clk_sys);
    #1 rst_b = 1'h1;
    i_admcc_host.step(2);
    // Reset state of the mode register and its outputs
    rd(8'h48, 16, r);
    chk("mode_config", 24'h00_0000, r);
    chk("chop_active", 1'h1, chop_active);
    chk("modulator_run", 1'h1, modulator_run);
    chk("rdy_b", 1'h1, rdy_b);
    chk("clk_pin_oe", 1'h0, clk_pin_oe);
    // Internal clock driven out, then withdrawn
    wr(8'h08, 16'h0040);
    chk("clk_pin_oe", 1'h1, clk_pin_oe);
    v = clk_pin_o;
    for (int i = 0; i < 2100 && clk_pin_o === v; i++) i_admcc_host.step(1);
    chk("clk_pin_o toggles", 1'h1, clk_pin_o !== v);
    wr(8'h08, 16'h0000);
    chk("clk_pin_oe", 1'h0, clk_pin_oe);
    // External clock, rate 3, chop on: 64 ticks a period
    wr(8'h08, 16'h0083);
    t0 = cyc;
    chk("update_rate_select", 4'h3, update_rate_select);
    wait_rdy();
    chk_win("first result", 1024, cyc - t0);
    t0 = cyc;
    rd(8'h40, 8, r);
    chk("status ready", 1'h0, r[7]);
    rd(8'h58, 24, r);
    chk("data", 24'hA5_0001, r);
    chk("rdy_b", 1'h1, rdy_b);
    filter_data = 24'h5A_0002;
    wait_rdy();
    chk_win("next result", 512, cyc - t0);
    rd(8'h58, 24, r);
    chk("data", 24'h5A_0002, r);
    // Halved external clock, rate 0, chop off with narrow common mode
    wr(8'h08, 16'h02D0);
    t0 = cyc;
    chk("chop_active", 1'h0, chop_active);
    chk("amp", 1'h1, amp_common_mode_narrow);
    chk("update_rate_select", 4'h0, update_rate_select);
    wait_rdy();
    chk_win("first result", 256, cyc - t0);
    // Continuous read: results leave with no command between them
    filter_data = 24'hC3_0003;
    i_admcc_host.sel(1'h0);
    i_admcc_host.bits(8, 24'h00_005C, r);
    i_admcc_host.bits(24, 24'h00_0000, r);
    chk("cont data", 24'h5A_0002, r);
    wait_rdy();
    i_admcc_host.bits(24, 24'h00_0000, r);
    chk("cont data", 24'hC3_0003, r);
    i_admcc_host.sel(1'h1);
    // Buffer fills while unread; a stall loses no word
    filter_data = 24'h3C_0004;
    i_admcc_host.step(1300);
    filter_data = 24'h96_0005;
    rd(8'h58, 24, r);
    chk("full data", 24'h3C_0004, r);
    rd(8'h58, 24, r);
    chk("full data", 24'h3C_0004, r);
    // Word held back by the full buffer comes out next
    wait_rdy();
    rd(8'h58, 24, r);
    chk("held data", 24'h3C_0004, r);
    wait_rdy();
    rd(8'h58, 24, r);
    chk("after stall", 24'h96_0005, r);
    // Idle stops conversions; drain any word that slipped in
    wr(8'h08, 16'h42D0);
    for (int i = 0; i < 2 && rdy_b === 1'h0; i++) rd(8'h58, 24, r);
    // Unmapped write is dropped, unmapped read is zero
    wr(8'h10, 16'hFFFF);
    rd(8'h48, 16, r);
    chk("mode_config", 24'h00_42D0, r);
    rd(8'h50, 8, r);
    chk("unmapped", 24'h00_0000, r);
    // Single conversion, chop on, then power-down by itself
    filter_data = 24'h69_0006;
    wr(8'h08, 16'h20C0);
    t0 = cyc;
    chk("modulator_run", 1'h1, modulator_run);
    wait_rdy();
    chk_win("single result", 512, cyc - t0);
    rd(8'h48, 16, r);
    chk("mode_config", 24'h00_60C0, r);
    chk("modulator_run", 1'h0, modulator_run);
    rd(8'h58, 24, r);
    chk("data", 24'h69_0006, r);
    chk("rdy_b", 1'h1, rdy_b);
    finish_test();
  end
endmodule : tb_top
